// File: core/irq_mode_logic.sv
// Processor interrupt mode selection, request gating and vector choice
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R1 - Masked requests are ANDed with the global interrupt enable first.
// R2 - Final request only when exception, error and debug levels are all zero.
// R3 - Nonmaskable event bypasses enables, masks and mode.
// R4 - Compatibility mode when special vector off, boot vectors, or spacing zero.
// R5 - Vectored mode when enabled, spacing nonzero, vectored present, no external.
// R6 - External-controller mode when enabled, spacing nonzero, external present.
// R7 - Spacing forced to zero when neither vectored nor external mode is implemented.
// R8 - Reset enters compatibility mode.
// R9 - Compatibility dispatch offset 0x180, or 0x200 with special vector set.
// R10 - Pending field shows live requests on every read.
// R11 - Eight requests: pending AND mask; hardware 5..0 on 7..2, software on 1..0.
// R12 - Timer and performance counter merged onto hardware line 5.
// R13 - Cause shows timer and performance counter pending bits.
// R14 - Cycle counter can be stopped.
// R15 - Disable and enable instructions clear or set enable atomically.
// R16 - Programmable exception base used while boot vectors off.
// R17 - Read-only capability bits report the optional modes.
// R18 - Two software, six hardware, timer and performance counter sources.
// R19 - Vectored mode priority-encodes requests, bit 7 highest.
// R20 - Vector offset latched when the request is raised.
// R21 - External mode leaves priority and vector to the outside controller.
module irq_mode_logic
   import irq_mode_pkg::*;
#(
   parameter bit HAS_VECTORED = 1'b1,
   parameter bit HAS_EXTERNAL = 1'b1
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Interrupt sources, from pins
   input wire logic [HW_LINES-1:0] hw_request,
   input wire logic timer_irq,
   input wire logic perf_irq,
   input wire logic nonmaskable_event,
   // External controller
   input wire logic [5:0] ext_level,
   input wire logic [15:0] ext_vector_offset,
   // Pipeline side
   input wire logic ints_off_instruction,
   input wire logic ints_on_instruction,
   input wire logic irq_taken,
   input wire logic exc_set,
   input wire logic exc_return,
   output logic irq_request,
   output logic nmi_request,
   output logic [31:0] vector_address,
   output logic [1:0] mode_out
);
   logic [5:0] hw_meta, hw_sync;
   logic [2:0] spc_meta, spc_sync;
   logic ie, exception_level, error_level, boot_exception_vector_select, dm, iv, stop_count;
   logic [7:0] mask;
   logic [1:0] sw_req;
   logic [CT_VS_W-1:0] spacing;
   logic [31:0] exc_base, cycle_count;
   logic [7:0] pending, masked;
   logic [2:0] winner;
   logic any_req;
   irq_mode_e mode;
   logic [31:0] next_vector;
   logic compat_forced;
   logic gate_open;
   logic [31:0] vec_base;
   logic [31:0] compat_ofs;
   logic [31:0] vectored_ofs;
   logic [31:0] status_word;
   logic [31:0] cause_word;
   logic [31:0] control_word;
   logic [31:0] capability_word;
   logic [31:0] read_word;

   // The request map below is wired for exactly six plus two lines
   if (HW_LINES != 6 || SW_LINES != 2 || REQ_LINES != 8) begin : g_line_count
      $error("Request line counts are fixed at six plus two");
   end

   // Spacing field must fit inside the control word
   if (CT_VS_LO + CT_VS_W > 32) begin : g_spacing_fit
      $error("Spacing field does not fit the control word");
   end

   // Two-flop synchronisers for the hardware lines
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hw_meta <= 6'h00;
         hw_sync <= 6'h00;
      end else begin
         hw_meta <= hw_request;
         hw_sync <= hw_meta;
      end
   end

   // Timer, counter and nonmaskable pins get the same two stages
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         spc_meta <= 3'h0;
         spc_sync <= 3'h0;
      end else begin
         spc_meta <= {nonmaskable_event, perf_irq, timer_irq};
         spc_sync <= spc_meta;
      end
   end

   // Live pending field; timer and counter share the top hardware line
   always_comb begin
      pending = 8'h00;
      pending[7] = hw_sync[5] | spc_sync[0] | spc_sync[1]; // R12
      pending[6:2] = hw_sync[4:0]; // R11 R18
      pending[1:0] = sw_req; // R11
      masked = pending & mask; // R11
   end

   // Any one of these pins the block to compatibility mode
   always_comb begin
      compat_forced = 1'b0;
      if (iv == 1'b0) begin
         compat_forced = 1'b1; // R4
      end
      if (boot_exception_vector_select == 1'b1) begin
         compat_forced = 1'b1; // R4
      end
      if (spacing == '0) begin
         compat_forced = 1'b1; // R4
      end
   end

   // Mode from control and capability fields; external outranks vectored
   always_comb begin
      if (compat_forced) begin
         mode = MODE_COMPAT; // R4 R8
      end else if (HAS_EXTERNAL) begin
         mode = MODE_EXTERNAL; // R6
      end else if (HAS_VECTORED) begin
         mode = MODE_VECTORED; // R5
      end else begin
         mode = MODE_COMPAT; // R7
      end
   end

   // Priority encoder, highest line wins
   always_comb begin
      winner = 3'h0;
      for (int i = 0; i < REQ_LINES; i++) begin
         if (masked[i]) begin
            winner = 3'(i); // R19
         end
      end
   end

   always_comb begin
      unique case (mode)
         MODE_EXTERNAL: any_req = (ext_level != 6'h00); // R21
         default: any_req = |masked; // R11
      endcase
   end

   // Boot vectors sit below the fixed boot address; otherwise the programmable base
   always_comb begin
      if (boot_exception_vector_select) begin
         vec_base = BOOT_BASE - 32'h00000200;
      end else begin
         vec_base = exc_base; // R16
      end
   end

   always_comb begin
      if (iv) begin
         compat_ofs = 32'(OFS_SPECIAL); // R9
      end else begin
         compat_ofs = 32'(OFS_GENERAL); // R9
      end
   end

   // Each vector slot is spacing times 32 bytes above the special offset
   always_comb begin
      vectored_ofs = 32'(OFS_SPECIAL) + (32'(winner) * 32'({spacing, 5'h00})); // R19
   end

   // Vector address for an interrupt in the current mode
   always_comb begin
      unique case (mode)
         MODE_VECTORED: next_vector = vec_base + vectored_ofs; // R19
         MODE_EXTERNAL: next_vector = vec_base + {16'h0000, ext_vector_offset}; // R21
         default: next_vector = vec_base + compat_ofs; // R9
      endcase
   end

   // Global enable: a status write wins, then disable over enable
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ie <= 1'b0;
      end else if (reg_wr && reg_addr == ADDR_STATUS) begin
         ie <= reg_wdata[ST_IE]; // R1
      end else if (ints_off_instruction) begin
         ie <= 1'b0; // R15
      end else if (ints_on_instruction) begin
         ie <= 1'b1; // R15
      end
   end

   // Error, boot and debug flags and the mask change only by software
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         error_level <= 1'b1;
         boot_exception_vector_select <= 1'b1; // R8
         dm <= 1'b0;
         mask <= 8'h00;
      end else if (reg_wr && reg_addr == ADDR_STATUS) begin
         error_level <= reg_wdata[ST_ERL];
         boot_exception_vector_select <= reg_wdata[ST_BEV];
         dm <= reg_wdata[ST_DM];
         mask <= reg_wdata[ST_IM_LO +: 8];
      end
   end

   // Exception level: set by the pipeline wins over software
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         exception_level <= 1'b0;
      end else if (exc_set || irq_taken) begin
         exception_level <= 1'b1;
      end else if (exc_return) begin
         exception_level <= 1'b0;
      end else if (reg_wr && reg_addr == ADDR_STATUS) begin
         exception_level <= reg_wdata[ST_EXL];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         iv <= 1'b0;
         sw_req <= 2'h0;
      end else if (reg_wr && reg_addr == ADDR_CAUSE) begin
         iv <= reg_wdata[CA_IV];
         sw_req <= reg_wdata[CA_IP_LO +: 2];
      end
   end

   // Counter stop bit, kept apart from the request fields
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         stop_count <= 1'b0;
      end else if (reg_wr && reg_addr == ADDR_CAUSE) begin
         stop_count <= reg_wdata[CA_DC]; // R14
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         spacing <= '0;
      end else if (reg_wr && reg_addr == ADDR_CONTROL) begin
         spacing <= (HAS_VECTORED || HAS_EXTERNAL) ? reg_wdata[CT_VS_LO +: CT_VS_W] : '0; // R7
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         exc_base <= EXC_BASE_RST;
      end else if (reg_wr && reg_addr == ADDR_EXC_BASE) begin
         exc_base <= {2'b10, reg_wdata[29:12], 12'h000}; // R16
      end
   end

   // Cycle counter, halted while stopped to save power
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cycle_count <= 32'h00000000;
      end else if (reg_wr && reg_addr == ADDR_CYCLE) begin
         cycle_count <= reg_wdata;
      end else if (!stop_count) begin
         cycle_count <= cycle_count + 32'h00000001; // R14
      end
   end

   // Every level flag blocks the request, not only the enable
   always_comb begin
      gate_open = ie; // R1
      if (exception_level || error_level || dm) begin
         gate_open = 1'b0; // R2
      end
   end

   // Final request and latched vector
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irq_request <= 1'b0;
         vector_address <= 32'h00000000;
      end else begin
         irq_request <= any_req & gate_open; // R1 R2
         // Vector held while a request stands, so a dropped line cannot move it
         if (!irq_request) begin
            vector_address <= next_vector; // R20
         end
      end
   end

   // Nonmaskable path ignores all interrupt gating
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         nmi_request <= 1'b0;
         mode_out <= MODE_COMPAT;
      end else begin
         nmi_request <= spc_sync[2]; // R3
         mode_out <= mode;
      end
   end

   // Register images, assembled one field at a time
   always_comb begin
      status_word = 32'h00000000;
      status_word[ST_IE] = ie;
      status_word[ST_EXL] = exception_level;
      status_word[ST_ERL] = error_level;
      status_word[ST_BEV] = boot_exception_vector_select;
      status_word[ST_DM] = dm;
      status_word[ST_IM_LO +: REQ_LINES] = mask;
   end

   // Pending bits follow the synchronised lines, not a captured copy
   always_comb begin
      cause_word = 32'h00000000;
      cause_word[CA_IP_LO +: REQ_LINES] = pending; // R10
      cause_word[CA_IV] = iv;
      cause_word[CA_TI] = spc_sync[0]; // R13
      cause_word[CA_PCI] = spc_sync[1]; // R13
      cause_word[CA_DC] = stop_count; // R14
   end

   always_comb begin
      control_word = 32'h00000000;
      control_word[CT_VS_LO +: CT_VS_W] = spacing;
   end

   // Capability bits are fixed by the build, so writes have nowhere to land
   always_comb begin
      capability_word = 32'h00000000;
      capability_word[CP_VECTORED_MODE_PRESENT] = HAS_VECTORED; // R17
      capability_word[CP_EXTERNAL_CONTROLLER_PRESENT] = HAS_EXTERNAL; // R17
   end

   always_comb begin
      unique case (reg_addr)
         ADDR_STATUS: read_word = status_word;
         ADDR_CAUSE: read_word = cause_word;
         ADDR_CONTROL: read_word = control_word;
         ADDR_CAPABILITY: read_word = capability_word;
         ADDR_EXC_BASE: read_word = exc_base;
         ADDR_CYCLE: read_word = cycle_count;
         ADDR_VECTOR: read_word = vector_address;
         default: read_word = 32'h00000000;
      endcase
   end

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         reg_rdata <= read_word;
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end
endmodule
`default_nettype wire

// File: core/irq_mode_pkg.sv
// Constants for the processor interrupt mode and request logic
package irq_mode_pkg;
   // Register offsets (word addresses on the plain port)
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_CAUSE = 4'h1;
   localparam logic [3:0] ADDR_CONTROL = 4'h2;
   localparam logic [3:0] ADDR_CAPABILITY = 4'h3;
   localparam logic [3:0] ADDR_EXC_BASE = 4'h4;
   localparam logic [3:0] ADDR_CYCLE = 4'h5;
   localparam logic [3:0] ADDR_VECTOR = 4'h6;
   // Status word fields
   localparam int ST_IE = 0;
   localparam int ST_EXL = 1;
   localparam int ST_ERL = 2;
   localparam int ST_BEV = 22;
   localparam int ST_DM = 23;
   localparam int ST_IM_LO = 8;
   // Cause word fields
   localparam int CA_IP_LO = 8;
   localparam int CA_IV = 23;
   localparam int CA_PCI = 26;
   localparam int CA_TI = 30;
   localparam int CA_DC = 27;
   // Control word fields
   localparam int CT_VS_LO = 5;
   localparam int CT_VS_W = 5;
   // Capability word fields
   localparam int CP_VECTORED_MODE_PRESENT = 5;
   localparam int CP_EXTERNAL_CONTROLLER_PRESENT = 6;
   // Offsets and reset values
   localparam logic [11:0] OFS_GENERAL = 12'h180;
   localparam logic [11:0] OFS_SPECIAL = 12'h200;
   localparam logic [31:0] EXC_BASE_RST = 32'h80000000;
   localparam logic [31:0] BOOT_BASE = 32'hbfc00200;
   localparam int HW_LINES = 6;
   localparam int SW_LINES = 2;
   localparam int REQ_LINES = 8;
   typedef enum logic [1:0] {
      MODE_COMPAT = 2'b00,
      MODE_VECTORED = 2'b01,
      MODE_EXTERNAL = 2'b11
   } irq_mode_e;
endpackage

// File: sim/irq_mode_asserts.sv
// Port checker for the interrupt mode and request logic
`timescale 1ns/10ps
`default_nettype none
module irq_mode_asserts
   import irq_mode_pkg::*;
(
   // Watched ports
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic nonmaskable_event,
   input wire logic ints_off_instruction,
   input wire logic exc_set,
   input wire logic irq_request,
   input wire logic nmi_request,
   input wire logic [31:0] vector_address,
   input wire logic [1:0] mode_out
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   chk_rst_mode: assert property (disable iff (1'b0) !rst_n |=> mode_out == MODE_COMPAT)
      else $error("mode not compat after reset");
   chk_rd_idle: assert property ($past(reg_rd) == 1'b0 |-> reg_rdata == 32'h0)
      else $error("read data outside answer cycle");
   chk_unmapped_zero: assert property (reg_rd && reg_addr > ADDR_VECTOR |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   chk_vector_hold: assert property (irq_request && $past(irq_request) |-> $stable(vector_address))
      else $error("vector moved during request");
   chk_exc_drop: assert property (exc_set |-> ##2 !irq_request)
      else $error("request while exception level set");
   chk_off_drop: assert property (ints_off_instruction |-> ##2 !irq_request)
      else $error("request after disable");
   chk_nmi_pass: assert property (nonmaskable_event [*4] |=> nmi_request)
      else $error("nmi not passed");
   chk_nmi_quiet: assert property (!nonmaskable_event [*4] |=> !nmi_request)
      else $error("spurious nmi");
   cov_irq: cover property ($rose(irq_request));
   cov_nmi: cover property ($rose(nmi_request));
   cov_ext: cover property (mode_out == MODE_EXTERNAL);
endmodule
bind irq_mode_logic irq_mode_asserts irq_mode_asserts_i (.mclk, .rst_n, .reg_addr, .reg_rd,
   .reg_rdata, .nonmaskable_event, .ints_off_instruction, .exc_set, .irq_request,
   .nmi_request, .vector_address, .mode_out);
`default_nettype wire

// File: sim/irq_mode_logic_tb.sv
// Self-checking bench for the interrupt mode and request logic
`timescale 1ns/10ps
`default_nettype none
module irq_mode_logic_tb;
   import irq_mode_pkg::*;
   logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_pend = 0;
   logic ioff = 0, ion = 0, eset = 0, eret = 0, taken = 0, tim = 0, nmi = 0;
   logic [3:0] reg_addr = 0;
   logic [31:0] reg_wdata = 0, reg_rdata, vector_address;
   logic [5:0] hw_want = 0, hw_request, ext_level;
   logic [15:0] ext_vector_offset;
   logic timer_irq, perf_irq, nonmaskable_event, irq_request, nmi_request;
   logic [1:0] mode_out;
   logic [31:0] exp_q[$];
   int num_errors = 0, n_checks = 0, idx;
   always #2.5 mclk = ~mclk;
   irq_src_model irq_src_model_i (.mclk(mclk), .hw_want(hw_want), .timer_want(tim),
      .nmi_want(nmi), .hw_request(hw_request), .timer_irq(timer_irq), .perf_irq(perf_irq),
      .nonmaskable_event(nonmaskable_event), .ext_level(ext_level),
      .ext_vector_offset(ext_vector_offset));
   irq_mode_logic irq_mode_logic_i (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .hw_request(hw_request), .timer_irq(timer_irq), .perf_irq(perf_irq),
      .nonmaskable_event(nonmaskable_event), .ext_level(ext_level),
      .ext_vector_offset(ext_vector_offset), .ints_off_instruction(ioff),
      .ints_on_instruction(ion), .irq_taken(taken), .exc_set(eset), .exc_return(eret),
      .irq_request(irq_request), .nmi_request(nmi_request),
      .vector_address(vector_address), .mode_out(mode_out));
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         num_errors++;
         $display("[ERR] %0t got %h want %h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
   endtask
   // Single-cycle pipeline strobe: 0 off, 1 on, 2 exception, 3 return
   task automatic pulse(input int which);
      case (which)
         0: ioff <= 1'b1;
         1: ion <= 1'b1;
         2: eset <= 1'b1;
         default: eret <= 1'b1;
      endcase
      @(posedge mclk);
      ioff <= 1'b0;
      ion <= 1'b0;
      eset <= 1'b0;
      eret <= 1'b0;
   endtask
   task automatic wait_on(ref logic s, input logic v);
      for (int i = 0; i < 20 && s !== v; i++)
         @(posedge mclk);
      check(32'(s), 32'(v));
      if (s !== v)
         final_report();
   endtask
   // Answer stands one cycle after the strobe, so look there only
   always @(posedge mclk)
      rd_pend <= reg_rd;
   always @(negedge mclk)
      if (rd_pend)
         check(reg_rdata, exp_q.pop_front());
   initial begin
      void'($urandom(61));
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      check(32'(mode_out), 32'(MODE_COMPAT));
      rd(ADDR_STATUS, 32'h00400004);
      rd(ADDR_EXC_BASE, EXC_BASE_RST);
      wr(ADDR_CAPABILITY, 32'h0);
      rd(ADDR_CAPABILITY, 32'h60);
      rd(4'hf, 32'h0);
      wr(ADDR_STATUS, 32'h0000ff01);
      idx = $urandom_range(5);
      hw_want <= 6'h1 << idx;
      wait_on(irq_request, 1'b1);
      check(vector_address, EXC_BASE_RST + OFS_GENERAL);
      rd(ADDR_CAUSE, 32'h1 << (idx + 10));
      pulse(0);
      wait_on(irq_request, 1'b0);
      pulse(1);
      wait_on(irq_request, 1'b1);
      pulse(2);
      wait_on(irq_request, 1'b0);
      pulse(3);
      wait_on(irq_request, 1'b1);
      wr(ADDR_STATUS, 32'h00000001);
      wait_on(irq_request, 1'b0);
      hw_want <= 6'h0;
      tim <= 1'b1;
      wr(ADDR_STATUS, 32'h00008001);
      wait_on(irq_request, 1'b1);
      rd(ADDR_CAUSE, 32'h40008000);
      pulse(0);
      wait_on(irq_request, 1'b0);
      wr(ADDR_CAUSE, 32'h00800000);
      pulse(1);
      wait_on(irq_request, 1'b1);
      check(vector_address, EXC_BASE_RST + OFS_SPECIAL);
      wr(ADDR_CONTROL, 32'h20);
      rd(ADDR_CONTROL, 32'h20);
      check(32'(mode_out), 32'(MODE_EXTERNAL));
      wr(ADDR_STATUS, 32'h00408001);
      rd(ADDR_CONTROL, 32'h20);
      check(32'(mode_out), 32'(MODE_COMPAT));
      pulse(0);
      nmi <= 1'b1;
      wait_on(nmi_request, 1'b1);
      final_report();
   end
endmodule
`default_nettype wire

// File: sim/irq_src_model.sv
// Behavioural model of the interrupt sources at the pins
`timescale 1ns/10ps
`default_nettype none
module irq_src_model (
   // Clock and wanted levels
   input wire logic mclk,
   input wire logic [5:0] hw_want,
   input wire logic timer_want,
   input wire logic nmi_want,
   // Source pins
   output var logic [5:0] hw_request = 6'h0,
   output var logic timer_irq = 1'b0,
   output var logic perf_irq = 1'b0,
   output var logic nonmaskable_event = 1'b0,
   output logic [5:0] ext_level,
   output logic [15:0] ext_vector_offset
);
   // Levels held until withdrawn, like real request lines
   always @(posedge mclk) begin
      hw_request <= hw_want;
      timer_irq <= timer_want;
      nonmaskable_event <= nmi_want;
   end
   // No outside controller fitted, so it never requests
   assign ext_level = 6'h0;
   assign ext_vector_offset = 16'h0;
endmodule
`default_nettype wire
